/* File: design/sbel_regs.svh */
// register offsets, field positions and reset values of the bus error log
//
// Operation
// - first log holds one error unless simultaneous
// - later errors go to next log
// - no first-log capture while any bit set
// - same-cycle errors all latch into first log
// - log bits survive ordinary reset
// - write one clears, zero leaves bit
// - first log at 0x60, 16 bits, top reserved
// - bit 9 I/O data parity, non-fatal
// - bit 8 memory data parity, non-fatal
// - bit 7 bus reinit assertion edge, fatal
// - bit 6 machine check edge, not self-driven
// - bit 5 lock outside DRAM, non-fatal
// - bit 4 address above top and 4GB
// - bit 3 bus data parity, non-fatal
// - bit 2 address strobe glitch, fatal
// - bit 1 data strobe glitch, fatal
// - bit 0 request/address parity, fatal
// - next log at 0x62, same layout
// - masked errors never logged, default 0x0009
`ifndef SBEL_REGS_SVH
`define SBEL_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SBEL_FIRST_OFS     8'h60
`define SBEL_NEXT_OFS      8'h62
`define SBEL_MASK_OFS      8'h64

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define SBEL_NUM_SRC       10
`define SBEL_BIT_IO_PAR    9
`define SBEL_BIT_MEM_PAR   8
`define SBEL_BIT_REINIT    7
`define SBEL_BIT_MCHECK    6
`define SBEL_BIT_LOCK      5
`define SBEL_BIT_ATOP      4
`define SBEL_BIT_DPAR      3
`define SBEL_BIT_AGLITCH   2
`define SBEL_BIT_DGLITCH   1
`define SBEL_BIT_RPAR      0

// ----------------------------------------------------------------
// reset values and fatal class map
// ----------------------------------------------------------------
`define SBEL_FIRST_RST     10'h000
`define SBEL_NEXT_RST      10'h000
`define SBEL_MASK_RST      10'h009
`define SBEL_FATAL_MAP     10'h087

`endif

/* File: design/sbel_pkg.sv */
// types shared by the bus error log
package sbel_pkg;
  typedef logic [9:0]  sbel_err_t;
  typedef logic [7:0]  sbel_addr_t;
  typedef logic [15:0] sbel_data_t;
endpackage

/* File: design/sbel_error_log.sv */
// bus first/next error log with mask and write-one-to-clear access
`timescale 1ns/1ps
`default_nettype none
`include "sbel_regs.svh"

module sbel_error_log
  import sbel_pkg::*;
(
  // clock and resets
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       powerOnRst,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [15:0] regRdData,
  // error detectors, same clock, one-cycle pulses
  input  wire logic       ioParityErr,
  input  wire logic       memParityErr,
  input  wire logic       lockOutsideDramError,
  input  wire logic       addressAboveTopError,
  input  wire logic       busDataParityError,
  input  wire logic       addressStrobeGlitchError,
  input  wire logic       dataStrobeGlitchError,
  input  wire logic       requestAddressParityError,
  // bus pins, active low, and own-drive flag, active high; all asynchronous
  input  wire logic       busReinitSignal_n,
  input  wire logic       machineCheckErrorSignal_n,
  input  wire logic       machineCheckDriven,
  // summary flags
  output logic            fatalLogged,
  output logic            nonFatalLogged
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic reinitMeta;
  logic reinitSync;
  logic reinitPrev;
  logic mcheckMeta;
  logic mcheckSync;
  logic mcheckPrev;
  logic ownMeta;
  logic ownSync;

  // two flops per pin; first flop read only by the second
  always_ff @(posedge clk) begin
    reinitMeta <= ~busReinitSignal_n;
    reinitSync <= reinitMeta;
    mcheckMeta <= ~machineCheckErrorSignal_n;
    mcheckSync <= mcheckMeta;
    ownMeta    <= machineCheckDriven;
    ownSync    <= ownMeta;
  end

  // previous level, reset to idle so no false edge after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      reinitPrev <= 1'b0;
      mcheckPrev <= 1'b0;
    end else begin
      reinitPrev <= reinitSync;
      mcheckPrev <= mcheckSync;
    end
  end

  // ----------------------------------------------------------------
  // raw error vector
  // ----------------------------------------------------------------
  sbel_err_t rawErr;
  sbel_err_t mask;
  sbel_err_t detErr;
  sbel_err_t firstLog;
  sbel_err_t nextLog;
  sbel_err_t next_firstLog;
  sbel_err_t next_nextLog;
  sbel_err_t clrBits;
  logic      writeFirst;
  logic      writeNext;
  logic      writeMask;

  always_comb begin
    rawErr = '0;
    rawErr[`SBEL_BIT_IO_PAR]  = ioParityErr;
    rawErr[`SBEL_BIT_MEM_PAR] = memParityErr;
    rawErr[`SBEL_BIT_REINIT]  = reinitSync & ~reinitPrev;
    rawErr[`SBEL_BIT_MCHECK]  = mcheckSync & ~mcheckPrev & ~ownSync;
    rawErr[`SBEL_BIT_LOCK]    = lockOutsideDramError;
    rawErr[`SBEL_BIT_ATOP]    = addressAboveTopError;
    rawErr[`SBEL_BIT_DPAR]    = busDataParityError;
    rawErr[`SBEL_BIT_AGLITCH] = addressStrobeGlitchError;
    rawErr[`SBEL_BIT_DGLITCH] = dataStrobeGlitchError;
    rawErr[`SBEL_BIT_RPAR]    = requestAddressParityError;
  end

  // masked sources never reach either log
  assign detErr = rawErr & ~mask;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign writeFirst = regWr && (regAddr == `SBEL_FIRST_OFS);
  assign writeNext  = regWr && (regAddr == `SBEL_NEXT_OFS);
  assign writeMask  = regWr && (regAddr == `SBEL_MASK_OFS);
  assign clrBits    = regWrData[9:0];

  // ----------------------------------------------------------------
  // log update
  // ----------------------------------------------------------------
  // the capture decision uses the log before this cycle's clear, so an
  // error racing a clear is never lost: set wins over clear
  always_comb begin
    next_firstLog = firstLog;
    next_nextLog  = nextLog;
    if (writeFirst) begin
      next_firstLog = firstLog & ~clrBits;
    end
    if (writeNext) begin
      next_nextLog = nextLog & ~clrBits;
    end
    // capture all same-cycle errors only when empty
    if (firstLog == '0) begin
      next_firstLog = next_firstLog | detErr;
    end else begin
      next_nextLog = next_nextLog | detErr;
    end
  end

  // logs ignore srst; of the two resets only power-on reset clears them
  always_ff @(posedge clk) begin
    if (powerOnRst) begin
      firstLog <= `SBEL_FIRST_RST;
      nextLog  <= `SBEL_NEXT_RST;
    end else begin
      firstLog <= next_firstLog;
      nextLog  <= next_nextLog;
    end
  end

  // mask register, sticky like the logs
  always_ff @(posedge clk) begin
    if (powerOnRst) begin
      mask <= `SBEL_MASK_RST;
    end else if (writeMask) begin
      mask <= regWrData[9:0];
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  // reserved bits 15:10 read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData <= '0;
    end else if (regRd) begin
      case (regAddr)
        `SBEL_FIRST_OFS: regRdData <= {6'h00, firstLog};
        `SBEL_NEXT_OFS:  regRdData <= {6'h00, nextLog};
        `SBEL_MASK_OFS:  regRdData <= {6'h00, mask};
        default:         regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end

  // fatal/non-fatal summary of everything logged
  always_ff @(posedge clk) begin
    if (srst) begin
      fatalLogged    <= 1'b0;
      nonFatalLogged <= 1'b0;
    end else begin
      fatalLogged    <= |((firstLog | nextLog) & `SBEL_FATAL_MAP);
      nonFatalLogged <= |((firstLog | nextLog) & ~`SBEL_FATAL_MAP);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_firstEmptyErr;
    (firstLog == '0) && (detErr != '0);
  endsequence

  a_first_capture_all: assert property (@(posedge clk) disable iff (powerOnRst)
    s_firstEmptyErr |=> ((firstLog & $past(detErr)) == $past(detErr)))
    else $error("first log missed simultaneous errors");

  a_first_frozen_set: assert property (@(posedge clk) disable iff (powerOnRst)
    (firstLog != '0) |=> ((firstLog & ~$past(firstLog)) == '0))
    else $error("first log gained bit while holding one");

  a_next_gets_later: assert property (@(posedge clk) disable iff (powerOnRst)
    ((firstLog != '0) && (detErr != '0)) |=> ((nextLog & $past(detErr)) == $past(detErr)))
    else $error("later error not in next log");

  a_first_one_hot: assert property (@(posedge clk) disable iff (powerOnRst)
    ((firstLog == '0) && $onehot(detErr)) |=> $onehot(firstLog))
    else $error("single first error did not set one bit");

  a_mask_blocks_log: assert property (@(posedge clk) disable iff (powerOnRst)
    ((rawErr & mask) != '0) && !writeMask |=>
      (((firstLog & ~$past(firstLog)) | (nextLog & ~$past(nextLog))) & $past(rawErr & mask)) == '0)
    else $error("masked error logged");

  a_clear_zero_keeps: assert property (@(posedge clk) disable iff (powerOnRst)
    writeFirst |=> ((firstLog & $past(firstLog & ~clrBits)) == $past(firstLog & ~clrBits)))
    else $error("write of zero cleared a bit");

  a_clear_one_clears: assert property (@(posedge clk) disable iff (powerOnRst)
    (writeNext && (nextLog != '0) && (detErr == '0) && (firstLog == '0)) |=>
      ((nextLog & $past(clrBits)) == '0))
    else $error("write of one did not clear");

  a_sticky_warm_rst: assert property (@(posedge clk) disable iff (powerOnRst)
    (srst && !regWr && (detErr == '0)) |=> (firstLog == $past(firstLog)))
    else $error("warm reset disturbed log");

  a_reinit_edge_log: assert property (@(posedge clk) disable iff (powerOnRst)
    (rawErr[`SBEL_BIT_REINIT] && !mask[`SBEL_BIT_REINIT]) |=>
      (firstLog[`SBEL_BIT_REINIT] || nextLog[`SBEL_BIT_REINIT]))
    else $error("reinit edge not logged");

  a_mcheck_own_quiet: assert property (@(posedge clk) disable iff (powerOnRst)
    ownSync |-> !rawErr[`SBEL_BIT_MCHECK])
    else $error("own machine check logged");

  a_read_reserved_zero: assert property (@(posedge clk) disable iff (srst)
    regRd |=> (regRdData[15:10] == 6'h00))
    else $error("reserved read bits not zero");

  // ----------------------------------------------------------------
  // pin paths
  // ----------------------------------------------------------------
  // a pin fall shorter than a clock may slip past the synchroniser, so
  // these checks only claim a fall seen on two samples after two quiet
  // ones; the log then shows the bit two edges after the last of them
  sequence s_reinitPinFall;
    busReinitSignal_n ##1 busReinitSignal_n ##1 !busReinitSignal_n ##1 !busReinitSignal_n;
  endsequence

  sequence s_reinitLogOpen;
    !mask[`SBEL_BIT_REINIT] && !powerOnRst;
  endsequence

  sequence s_mcheckPinFall;
    machineCheckErrorSignal_n ##1 machineCheckErrorSignal_n ##1 !machineCheckErrorSignal_n ##1
      !machineCheckErrorSignal_n;
  endsequence

  // own drive, seen through its synchroniser, closes the path
  sequence s_mcheckLogOpen;
    !mask[`SBEL_BIT_MCHECK] && !ownSync && !powerOnRst;
  endsequence

  a_reinit_pin_path: assert property (@(posedge clk) disable iff (powerOnRst)
    (s_reinitPinFall ##1 s_reinitLogOpen) |=> (firstLog[`SBEL_BIT_REINIT] || nextLog[`SBEL_BIT_REINIT]))
    else $error("reinit pin fall not logged");

  // foreign machine check fall is logged
  a_mcheck_pin_path: assert property (@(posedge clk) disable iff (powerOnRst)
    (s_mcheckPinFall ##1 s_mcheckLogOpen) |=> (firstLog[`SBEL_BIT_MCHECK] || nextLog[`SBEL_BIT_MCHECK]))
    else $error("machine check pin fall not logged");

  // own drive keeps the log closed
  a_mcheck_own_closed: assert property (@(posedge clk) disable iff (powerOnRst)
    (s_mcheckPinFall ##1 (ownSync && !firstLog[`SBEL_BIT_MCHECK] && !nextLog[`SBEL_BIT_MCHECK]))
      |=> !(firstLog[`SBEL_BIT_MCHECK] || nextLog[`SBEL_BIT_MCHECK]))
    else $error("own machine check drive logged");

  // ----------------------------------------------------------------
  // register port readback
  // ----------------------------------------------------------------
  // first log reads back as held
  a_read_first_log: assert property (@(posedge clk) disable iff (srst)
    (regRd && (regAddr == `SBEL_FIRST_OFS)) |=> (regRdData == {6'h00, $past(firstLog)}))
    else $error("first log read data wrong");

  // next log reads back as held
  a_read_next_log: assert property (@(posedge clk) disable iff (srst)
    (regRd && (regAddr == `SBEL_NEXT_OFS)) |=> (regRdData == {6'h00, $past(nextLog)}))
    else $error("next log read data wrong");

  a_read_mask_reg: assert property (@(posedge clk) disable iff (srst)
    (regRd && (regAddr == `SBEL_MASK_OFS)) |=> (regRdData == {6'h00, $past(mask)}))
    else $error("mask read data wrong");

  a_read_unmapped_zero: assert property (@(posedge clk) disable iff (srst)
    (regRd && (regAddr != `SBEL_FIRST_OFS) && (regAddr != `SBEL_NEXT_OFS) && (regAddr != `SBEL_MASK_OFS))
      |=> (regRdData == 16'h0000))
    else $error("unmapped offset read not zero");

  a_read_idle_zero: assert property (@(posedge clk) disable iff (srst)
    !regRd |=> (regRdData == 16'h0000))
    else $error("read data stood past its cycle");

  // ----------------------------------------------------------------
  // stickiness and clearing
  // ----------------------------------------------------------------
  // power-on reset clears logs, sets mask
  a_por_clears_all: assert property (@(posedge clk)
    powerOnRst |=> ((firstLog == '0) && (nextLog == '0) && (mask == `SBEL_MASK_RST)))
    else $error("power-on reset left log or mask");

  a_mask_warm_keep: assert property (@(posedge clk) disable iff (powerOnRst)
    !writeMask |=> (mask == $past(mask)))
    else $error("mask changed without a write");

  // first log bits leave only on a write
  a_first_bits_stick: assert property (@(posedge clk) disable iff (powerOnRst)
    !writeFirst |=> ((firstLog & $past(firstLog)) == $past(firstLog)))
    else $error("first log bit dropped without a write");

  // next log bits leave only on a write
  a_next_bits_stick: assert property (@(posedge clk) disable iff (powerOnRst)
    !writeNext |=> ((nextLog & $past(nextLog)) == $past(nextLog)))
    else $error("next log bit dropped without a write");

  a_first_clear_ones: assert property (@(posedge clk) disable iff (powerOnRst)
    (writeFirst && (firstLog != '0)) |=> ((firstLog & $past(clrBits)) == '0))
    else $error("one written to first log did not clear");

  a_next_clear_ones: assert property (@(posedge clk) disable iff (powerOnRst)
    (writeNext && (detErr == '0)) |=> ((nextLog & $past(clrBits)) == '0))
    else $error("one written to next log did not clear");

  a_mask_write_lands: assert property (@(posedge clk) disable iff (powerOnRst)
    writeMask |=> (mask == $past(regWrData[9:0])))
    else $error("mask write did not land");

  // nothing spills to next while first empty
  a_no_spill_next: assert property (@(posedge clk) disable iff (powerOnRst)
    (firstLog == '0) |=> ((nextLog & ~$past(nextLog)) == '0))
    else $error("error spilled to next log while first was empty");

  // ----------------------------------------------------------------
  // summary flags
  // ----------------------------------------------------------------
  // flags lag the logs by one edge; srst forces them low
  // fatal flag follows fatal bits
  a_fatal_flag_follow: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> (fatalLogged == $past(|((firstLog | nextLog) & `SBEL_FATAL_MAP))))
    else $error("fatal flag out of step with logs");

  a_nonfatal_flag_follow: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> (nonFatalLogged == $past(|((firstLog | nextLog) & ~`SBEL_FATAL_MAP))))
    else $error("non-fatal flag out of step with logs");

  a_flags_warm_low: assert property (@(posedge clk)
    srst |=> (!fatalLogged && !nonFatalLogged))
    else $error("summary flags high after warm reset");

endmodule
`default_nettype wire

/* File: verification/sbel_bus_agent.sv */
// far-side model: error detectors and the active-low bus pins
`timescale 1ns/1ps
`default_nettype none

module sbel_bus_agent
  import sbel_pkg::*;
(
  // clock
  input  wire logic      clk,
  // requests from the bench: fire as one-cycle pulses, selfDrive as a level
  input  wire sbel_err_t fire,
  input  wire logic      selfDrive,
  // detector pulses and pins
  output var  sbel_err_t detOut,
  output logic           busReinitSignal_n,
  output logic           machineCheckErrorSignal_n,
  output logic           machineCheckDriven
);
  // ----------------------------------------------------------------
  // pins and pulses
  // ----------------------------------------------------------------
  logic [2:0] reinitLow = '0;
  logic [2:0] mcheckLow = '0;

  // detectors fire one cycle after a request; pin sources never pulse here
  always_ff @(posedge clk) begin
    detOut <= fire & 10'h33f;
    machineCheckDriven <= selfDrive;
  end

  // pins held low four cycles so the synchroniser sees them, then pulled up
  always_ff @(posedge clk) begin
    reinitLow <= fire[7] ? 3'h4 : reinitLow - {2'b0, |reinitLow};
    mcheckLow <= fire[6] ? 3'h4 : mcheckLow - {2'b0, |mcheckLow};
  end
  assign busReinitSignal_n = ~|reinitLow;
  assign machineCheckErrorSignal_n = ~|mcheckLow;
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the bus error log
`timescale 1ns/1ps
`default_nettype none

module tb_top import sbel_pkg::*;;
  typedef struct {sbel_err_t fire; logic fatal;} sbel_row_s;
  logic       clk, srst, powerOnRst, regWr, regRd, selfDrive;
  logic       reinitN, mcheckN, mcDriven, fatalLogged, nonFatalLogged;
  sbel_addr_t regAddr;
  sbel_data_t regWrData, regRdData, rdv;
  sbel_err_t  fire, det;
  int         errCount, nCompared;
  // one row per source: detector request beside its fatal class
  sbel_row_s  rows[10] = '{'{10'h200, 1'b0}, '{10'h100, 1'b0}, '{10'h080, 1'b1}, '{10'h040, 1'b0},
    '{10'h020, 1'b0}, '{10'h010, 1'b0}, '{10'h008, 1'b0}, '{10'h004, 1'b1}, '{10'h002, 1'b1},
    '{10'h001, 1'b1}};

  sbel_bus_agent agent_u (.clk(clk), .fire(fire), .selfDrive(selfDrive), .detOut(det),
    .busReinitSignal_n(reinitN), .machineCheckErrorSignal_n(mcheckN), .machineCheckDriven(mcDriven));
  sbel_error_log dut_u (.clk(clk), .srst(srst), .powerOnRst(powerOnRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .ioParityErr(det[9]), .memParityErr(det[8]), .lockOutsideDramError(det[5]),
    .addressAboveTopError(det[4]), .busDataParityError(det[3]), .addressStrobeGlitchError(det[2]),
    .dataStrobeGlitchError(det[1]), .requestAddressParityError(det[0]), .busReinitSignal_n(reinitN),
    .machineCheckErrorSignal_n(mcheckN), .machineCheckDriven(mcDriven),
    .fatalLogged(fatalLogged), .nonFatalLogged(nonFatalLogged));

  // ----------------------------------------------------------------
  // clock and tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input sbel_data_t seen, input sbel_data_t exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input sbel_addr_t a, input sbel_data_t d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rc(input sbel_addr_t a, input sbel_data_t exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdData;
    chk(rdv, exp);
  endtask

  task automatic hit(input sbel_err_t v);
    @(posedge clk);
    fire <= v;
    @(posedge clk);
    fire <= '0;
    repeat (6) @(posedge clk);
  endtask

  task automatic rst(input logic pwr);
    @(posedge clk);
    srst <= 1'b1;
    powerOnRst <= pwr;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    powerOnRst <= 1'b0;
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {srst, powerOnRst, regWr, regRd, selfDrive} = 5'b11000;
    regAddr = '0;
    regWrData = '0;
    fire = '0;
    errCount = 0;
    nCompared = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    powerOnRst <= 1'b0;
    rc(8'h60, 16'h0000);
    rc(8'h62, 16'h0000);
    rc(8'h64, 16'h0009);
    hit(10'h008);
    rc(8'h60, 16'h0000);
    wr(8'h64, 16'h0000);
    foreach (rows[i]) begin
      hit(rows[i].fire);
      rc(8'h60, {6'b0, rows[i].fire});
      chk({15'b0, fatalLogged}, {15'b0, rows[i].fatal});
      chk({15'b0, nonFatalLogged}, {15'b0, ~rows[i].fatal});
      wr(8'h60, {6'b0, rows[i].fire});
      rc(8'h60, 16'h0000);
      $display("row %0d done", i);
    end
    // first error holds, later ones go to the next log, zero writes keep bits
    hit(10'h200);
    hit(10'h100);
    rc(8'h60, 16'h0200);
    @(posedge clk);
    #1 chk(regRdData, 16'h0000);
    rc(8'h62, 16'h0100);
    wr(8'h60, 16'h0000);
    rc(8'h60, 16'h0200);
    wr(8'h60, 16'h0200);
    wr(8'h62, 16'h0100);
    hit(10'h030);
    rc(8'h60, 16'h0030);
    rc(8'h62, 16'h0000);
    rc(8'h66, 16'h0000);
    $display("first/next test done");
    // own drive of the machine-check pin must not log
    @(posedge clk);
    selfDrive <= 1'b1;
    repeat (4) @(posedge clk);
    hit(10'h040);
    rc(8'h62, 16'h0000);
    selfDrive <= 1'b0;
    rst(1'b0);
    rc(8'h60, 16'h0030);
    rc(8'h64, 16'h0000);
    // set beats clear: an error in the clearing cycle lands in the next log
    @(posedge clk);
    fire <= 10'h100;
    @(posedge clk);
    fire <= '0;
    regAddr <= 8'h60;
    regWrData <= 16'h0030;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    rc(8'h60, 16'h0000);
    rc(8'h62, 16'h0100);
    rst(1'b1);
    rc(8'h60, 16'h0000);
    rc(8'h64, 16'h0009);
    $display("reset test done");
    summarize();
  end

  // watchdog well past the expected run length
  initial begin
    #50000;
    errCount++;
    $display("[FAIL] %0t ns: run hung", $time);
    summarize();
  end
endmodule
`default_nettype wire
